// >>> hw/csd_top.sv
// Purpose: power-up strap decode, pin ownership, stagger and link guards
// Assumes: pins synchronous to clk; rst asserted at power-up
// Notes: pins are open drain: output low while enable is high
`include "csd_cfg.svh"

module csd_top #(
	parameter int fwd_cyc = `CSD_FWD_MAX_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// straps and dual-purpose pins
	input wire logic local_cc_enable_strap,
	input wire logic cc_mode_select_pin,
	input wire logic general_io_zero_in,
	output logic general_io_zero_out,
	output logic general_io_zero_oe,
	input wire logic general_io_one_in,
	output logic general_io_one_out,
	output logic general_io_one_oe,
	input wire logic cc_rx_pin_in,
	output logic cc_rx_pin_out,
	output logic cc_rx_pin_oe,
	input wire logic cc_tx_pin_in,
	output logic cc_tx_pin_out,
	output logic cc_tx_pin_oe,
	// core side of the general io and control channel
	input wire logic [1:0] gpio_drive_low,
	output logic [1:0] gpio_state,
	input wire logic cc_rx_drive_low,
	input wire logic cc_tx_drive_low,
	output logic cc_rx_level,
	output logic cc_tx_level,
	// control channel rate guard
	input wire logic cc_i2c_mode,
	input wire logic rate_err_clear,
	output logic rate_err,
	// stagger control and latched configuration
	input wire logic stagger_disable,
	output csd_pkg::csd_stag_t stag,
	output csd_pkg::csd_strap_t cfg,
	output logic cfg_valid,
	// remote pins
	input wire logic remote_input_pin,
	output logic remote_output_pin
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	csd_pkg::csd_state_t state; // power-up sequence
	csd_pkg::csd_state_t next_state;
	logic [3:0] settle; // settle count before sampling
	logic [3:0] next_settle;
	csd_pkg::csd_strap_t next_cfg;
	logic next_cfg_valid;
	csd_pkg::csd_stag_t next_stag;
	logic od_level; // open-drain pins only ever drive low
	logic own; // control channel owns the pins
	logic next_gz_oe, next_go_oe, next_rx_oe, next_tx_oe;
	logic [1:0] next_gpio_state;
	logic next_rx_level, next_tx_level;

	assign own = (state == csd_pkg::ST_HOLD) && cfg.local_cc_en;

	// stagger code from a delay in ps
	function automatic logic [2:0] stag_code(input int ps);
		stag_code = 3'(ps / `CSD_STAG_STEP_PS);
	endfunction

	// ------------------------------------------------------------
	// power-up sampling
	// ------------------------------------------------------------
	// straps are read once after a short settle so pulldowns and board
	// drivers have stopped moving; after that only a reset re-reads them
	always_comb begin
		next_state = state;
		next_settle = settle;
		next_cfg = cfg;
		next_cfg_valid = cfg_valid;
		case (state)
			csd_pkg::ST_SETTLE: begin
				next_settle = settle + 4'h1;
				if (settle == `CSD_SETTLE_CYC) begin
					next_state = csd_pkg::ST_SAMPLE;
				end
			end
			csd_pkg::ST_SAMPLE: begin
				next_cfg = '0;
				next_cfg.local_cc_en = local_cc_enable_strap; // [RL1]
				if (local_cc_enable_strap) begin
					next_cfg.bypass_mode = cc_mode_select_pin; // [RL5]
				end else begin
					next_cfg.double_out = general_io_zero_in; // [RL3]
					next_cfg.bus_32 = general_io_one_in; // [RL4]
					next_cfg.sync_enc = cc_mode_select_pin; // [RL6]
					next_cfg.ecc_en = cc_rx_pin_in; // [RL7]
					next_cfg.fall_edge = cc_tx_pin_in; // [RL8]
				end
				next_cfg_valid = 1'b1;
				next_state = csd_pkg::ST_HOLD; // [RL2]
			end
			csd_pkg::ST_HOLD: begin
				next_state = csd_pkg::ST_HOLD; // later pin changes ignored [RL2]
			end
			default: begin
				next_state = csd_pkg::ST_SETTLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// pin ownership and stagger codes
	// ------------------------------------------------------------
	// in strap mode nothing drives the pins and the core sees an idle
	// high line, so strap levels never look like channel traffic
	always_comb begin
		next_gz_oe = own && gpio_drive_low[0]; // [RL1]
		next_go_oe = own && gpio_drive_low[1]; // [RL1]
		next_rx_oe = own && cc_rx_drive_low; // [RL14]
		next_tx_oe = own && cc_tx_drive_low; // [RL14]
		next_gpio_state = own ? {general_io_one_in, general_io_zero_in}
			: 2'h3;
		next_rx_level = own ? cc_rx_pin_in : 1'b1; // [RL14]
		next_tx_level = own ? cc_tx_pin_in : 1'b1; // [RL14]
		if (stagger_disable) begin
			next_stag = '0; // all aligned [RL13]
		end else begin
			next_stag.grp0 = stag_code(`CSD_STAG_G0_PS); // [RL9]
			next_stag.grp1 = stag_code(`CSD_STAG_G1_PS);
			next_stag.grp2 = stag_code(`CSD_STAG_G2_PS);
			next_stag.grp3 = stag_code(`CSD_STAG_G3_PS);
			next_stag.pclk = stag_code(`CSD_STAG_PCLK_PS);
		end
	end

	// registers of both groups above
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= csd_pkg::ST_SETTLE;
			settle <= 4'h0;
			cfg <= '0;
			cfg_valid <= 1'b0;
			stag <= '0;
			od_level <= 1'b0;
			general_io_zero_oe <= 1'b0;
			general_io_one_oe <= 1'b0;
			cc_rx_pin_oe <= 1'b0;
			cc_tx_pin_oe <= 1'b0;
			gpio_state <= 2'h3;
			cc_rx_level <= 1'b1;
			cc_tx_level <= 1'b1;
		end else begin
			state <= next_state;
			settle <= next_settle;
			cfg <= next_cfg;
			cfg_valid <= next_cfg_valid;
			stag <= next_stag;
			od_level <= 1'b0;
			general_io_zero_oe <= next_gz_oe;
			general_io_one_oe <= next_go_oe;
			cc_rx_pin_oe <= next_rx_oe;
			cc_tx_pin_oe <= next_tx_oe;
			gpio_state <= next_gpio_state;
			cc_rx_level <= next_rx_level;
			cc_tx_level <= next_tx_level;
		end
	end

	assign general_io_zero_out = od_level;
	assign general_io_one_out = od_level;
	assign cc_rx_pin_out = od_level;
	assign cc_tx_pin_out = od_level;

	// ------------------------------------------------------------
	// control channel rate guard
	// ------------------------------------------------------------
	// watches the received line in uart mode and the clock line in i2c
	// mode; an edge sooner than the least legal spacing sets a sticky
	// flag. only a limit check: it does not stop the traffic
	logic watch_prev; // watched line one cycle ago
	logic [7:0] gap; // cycles since last edge, saturating
	logic next_watch_prev;
	logic [7:0] next_gap;
	logic next_rate_err;
	logic watch;
	logic edge_seen;
	logic [7:0] min_gap;

	always_comb begin
		watch = cc_i2c_mode ? cc_tx_level : cc_rx_level;
		edge_seen = watch != watch_prev;
		min_gap = cc_i2c_mode ? 8'(`CSD_I2C_MIN_CYC) : 8'(`CSD_UART_MIN_CYC);
		next_watch_prev = watch;
		next_gap = (gap == 8'hff) ? gap : gap + 8'h1;
		next_rate_err = rate_err && !rate_err_clear;
		if (edge_seen) begin
			next_gap = 8'h0;
			if (gap < min_gap - 8'h1) begin
				next_rate_err = 1'b1; // set wins over clear [RL10]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			watch_prev <= 1'b1;
			gap <= 8'hff;
			rate_err <= 1'b0;
		end else begin
			watch_prev <= next_watch_prev;
			gap <= next_gap;
			rate_err <= next_rate_err;
		end
	end

	// ------------------------------------------------------------
	// remote input forwarding
	// ------------------------------------------------------------
	csd_remote_fwd #(
		.fwd_cyc(fwd_cyc)
	) u_fwd (
		.clk(clk),
		.rst(rst),
		.remote_input_pin(remote_input_pin),
		.remote_output_pin(remote_output_pin)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_hold_frozen: assert property (@(posedge clk) disable iff (rst) // [RL2]
		cfg_valid |=> cfg_valid && $stable(cfg))
		else $error("latched configuration moved");

	a_strap_gate: assert property (@(posedge clk) disable iff (rst) // [RL1]
		cfg_valid && !cfg.local_cc_en |=> !general_io_zero_oe
		&& !general_io_one_oe && !cc_rx_pin_oe && !cc_tx_pin_oe)
		else $error("pin driven in strap mode");

	a_cc_ignored: assert property (@(posedge clk) disable iff (rst) // [RL14]
		cfg_valid && !cfg.local_cc_en |=> cc_rx_level && cc_tx_level)
		else $error("channel traffic passed in strap mode");

	a_double_width: assert property (@(posedge clk) disable iff (rst) // [RL3] [RL4]
		state == csd_pkg::ST_SAMPLE && !local_cc_enable_strap
		|=> cfg.double_out == $past(general_io_zero_in)
		&& cfg.bus_32 == $past(general_io_one_in))
		else $error("double or width strap misread");

	a_sync_ecc: assert property (@(posedge clk) disable iff (rst) // [RL6] [RL7]
		state == csd_pkg::ST_SAMPLE && !local_cc_enable_strap
		|=> cfg.sync_enc == $past(cc_mode_select_pin)
		&& cfg.ecc_en == $past(cc_rx_pin_in))
		else $error("sync or ecc strap misread");

	a_edge_sel: assert property (@(posedge clk) disable iff (rst) // [RL8]
		state == csd_pkg::ST_SAMPLE && !local_cc_enable_strap
		|=> cfg.fall_edge == $past(cc_tx_pin_in) && !cfg.bypass_mode)
		else $error("edge strap misread");

	a_mode_sel: assert property (@(posedge clk) disable iff (rst) // [RL5]
		state == csd_pkg::ST_SAMPLE && local_cc_enable_strap
		|=> cfg.bypass_mode == $past(cc_mode_select_pin) && !cfg.double_out)
		else $error("mode pin misread");

	a_stag_on: assert property (@(posedge clk) disable iff (rst) // [RL9]
		!stagger_disable |=> stag.grp0 == 3'h0 && stag.grp1 == 3'h2
		&& stag.grp2 == 3'h4 && stag.grp3 == 3'h6 && stag.pclk == 3'h3)
		else $error("stagger codes wrong");

	a_stag_off: assert property (@(posedge clk) disable iff (rst) // [RL13]
		stagger_disable |=> stag == '0)
		else $error("stagger not removed");

	a_rate_flag: assert property (@(posedge clk) disable iff (rst) // [RL10]
		edge_seen && gap < min_gap - 8'h1 |=> rate_err)
		else $error("fast edge not flagged");

endmodule

// >>> hw/csd_cfg.svh
// Purpose: constants for the configuration strap decoder
// Assumes: 50 MHz clk, all pins synchronous to clk
// Notes: times are kept in their own units, cycle counts except the settle count derive from them
//
// Contract
// RL1 - enable strap low: pins become configuration inputs
// RL2 - straps latched once at power-up, then ignored
// RL3 - double-output strap: low single, high double
// RL4 - bus-width strap: low 24-bit, high 32-bit
// RL5 - mode pin: low base, high bypass
// RL6 - sync-encode strap: low off, high on
// RL7 - error-correct strap: low off, high on
// RL8 - edge strap: low rising, high falling edge
// RL9 - stagger groups 0/0.5/1/1.5 ns, clock 0.75
// RL10 - control channel rates: 1Mbps uart, 400kbps i2c
// RL11 - remote input reaches remote output within 0.35ms
// RL12 - driver spaces remote input transitions 0.35ms apart
// RL13 - stagger disable bit removes all delays
// RL14 - strap mode ignores control-channel pin traffic
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CSD_CLK_KHZ 50000
`define CSD_SETTLE_CYC 4'hf
// fastest legal rates in kbps
`define CSD_UART_MAX_KBPS 1000
`define CSD_I2C_MAX_KBPS 400
// least uart bit time, rounded up to cycles
`define CSD_UART_MIN_CYC \
	((`CSD_CLK_KHZ + `CSD_UART_MAX_KBPS - 1) / `CSD_UART_MAX_KBPS)
// least i2c clock half period, rounded up to cycles
`define CSD_I2C_MIN_CYC \
	((`CSD_CLK_KHZ + 2 * `CSD_I2C_MAX_KBPS - 1) / (2 * `CSD_I2C_MAX_KBPS))
// remote input to remote output, longest time in us, rounded down
`define CSD_FWD_MAX_US 350
`define CSD_FWD_MAX_CYC (`CSD_FWD_MAX_US * `CSD_CLK_KHZ / 1000)

// ------------------------------------------------------------
// stagger delays in ps and their code step
// ------------------------------------------------------------
`define CSD_STAG_STEP_PS 250
`define CSD_STAG_G0_PS 0
`define CSD_STAG_G1_PS 500
`define CSD_STAG_G2_PS 1000
`define CSD_STAG_G3_PS 1500
`define CSD_STAG_PCLK_PS 750
// location of the stagger disable control in the device map
`define CSD_STAG_REG_ADDR 8'h08
`define CSD_STAG_DIS_BIT 3

`endif

// >>> hw/csd_pkg.sv
// Purpose: shared types of the configuration strap decoder
// Assumes: nothing beyond the constants header
// Notes: all types are packed so they travel on plain ports
package csd_pkg;

	// ------------------------------------------------------------
	// latched configuration
	// ------------------------------------------------------------
	typedef struct packed {
		logic local_cc_en; // control channel owns the pins
		logic double_out; // half word per pixel clock
		logic bus_32; // 32-bit bus width, else 24-bit
		logic sync_enc; // hsync/vsync encoding on
		logic ecc_en; // link error detect/correct on
		logic fall_edge; // data valid on falling clock edge
		logic bypass_mode; // control channel bypass mode
	} csd_strap_t;

	// ------------------------------------------------------------
	// stagger delay codes, one step per 0.25 ns
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] grp0;
		logic [2:0] grp1;
		logic [2:0] grp2;
		logic [2:0] grp3;
		logic [2:0] pclk;
	} csd_stag_t;

	// ------------------------------------------------------------
	// power-up sequence
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_SETTLE = 3'h1,
		ST_SAMPLE = 3'h2,
		ST_HOLD = 3'h4
	} csd_state_t;

endpackage

// >>> hw/csd_gpi_fwd.sv
// Purpose: forwards remote input transitions to the remote output
// Assumes: input synchronous to clk, transitions spaced by the far side
// Notes: latency is fwd_cyc cycles, inside the longest allowed time
`include "csd_cfg.svh"

module csd_remote_fwd #(
	parameter int fwd_cyc = `CSD_FWD_MAX_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// remote pins
	input wire logic remote_input_pin,
	output logic remote_output_pin
);

	logic busy; // a transition is in flight
	logic held; // level being carried
	logic [19:0] cnt; // cycles left in flight
	logic next_busy;
	logic next_held;
	logic next_out;
	logic [19:0] next_cnt;

	// ------------------------------------------------------------
	// carry one transition at a time
	// ------------------------------------------------------------
	// a second change while busy is picked up after delivery; the far
	// side spaces its changes so none is lost [RL12]
	always_comb begin
		next_busy = busy;
		next_held = held;
		next_out = remote_output_pin;
		next_cnt = cnt;
		if (busy) begin
			if (cnt == 20'h0) begin
				next_out = held; // deliver [RL11]
				next_busy = 1'b0;
			end else begin
				next_cnt = cnt - 20'h1;
			end
		end else if (remote_input_pin != remote_output_pin) begin
			next_busy = 1'b1; // start the transit [RL11]
			next_held = remote_input_pin;
			next_cnt = 20'(fwd_cyc - 2);
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			held <= 1'b0;
			cnt <= 20'h0;
			remote_output_pin <= 1'b0;
		end else begin
			busy <= next_busy;
			held <= next_held;
			cnt <= next_cnt;
			remote_output_pin <= next_out;
		end
	end

	a_fwd_start: assert property (@(posedge clk) disable iff (rst) // [RL11]
		!busy && remote_input_pin != remote_output_pin
		|=> busy && cnt == 20'(fwd_cyc - 2))
		else $error("transit did not start with full count");

	a_fwd_deliver: assert property (@(posedge clk) disable iff (rst) // [RL11]
		busy && cnt == 20'h0 |=> remote_output_pin == $past(held) && !busy)
		else $error("transit did not deliver held level");

endmodule

// >>> tb/csd_board_model.sv
// Purpose: board side of the dual-purpose configuration pins
// Assumes: open-drain lines with pull-ups while the control channel owns them
// Notes: bit 0 io zero, bit 1 io one, bit 2 rx line, bit 3 tx line
module csd_board_model (
	// who owns the pins
	input wire logic strap_mode,
	input wire logic [3:0] strap_level,
	// far-side open-drain drivers
	input wire logic [3:0] peer_low,
	// design pin enables, high pulls low
	input wire logic [3:0] dut_oe,
	// resolved wire levels
	output logic [3:0] pin_level
);
	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// straps are resistors: in strap mode their level wins and any drive on the pin is ignored
	// wired-and otherwise, so a stale value can never linger on the line
	assign pin_level = strap_mode ? strap_level : ~(dut_oe | peer_low);
endmodule

// >>> tb/config_strap_decode_tb_top.sv
// Purpose: self-checking bench of the configuration strap decoder
// Assumes: 50 MHz clk, inputs driven at the falling edge
// Notes: forwarding count shortened to keep the run brief
`define CHK(what, exp, got) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("wrong value %s exp %h got %h", what, exp, got); \
	end \
end

module config_strap_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int fwd_n = 8; // short forwarding count
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, rst, lcc, msel, strap_mode, rx_dl, tx_dl, rx_lvl, tx_lvl;
	logic i2c, clr, rate_err, stag_dis, cfg_valid, rin, rout;
	logic [3:0] strap_level, peer_low, oe, pin;
	logic [3:0] od_out; // open-drain output levels, always low
	logic [1:0] gpio_drive_low, gpio_state;
	logic [15:0] lfsr, v;
	csd_pkg::csd_stag_t stag;
	csd_pkg::csd_strap_t cfg, e;
	int num_errors, n_checks, k;

	csd_top #(.fwd_cyc(fwd_n)) i_csd_top (
		.clk(clk), .rst(rst), .local_cc_enable_strap(lcc),
		.cc_mode_select_pin(msel),
		.general_io_zero_in(pin[0]),
		.general_io_zero_out(od_out[0]),
		.general_io_zero_oe(oe[0]),
		.general_io_one_in(pin[1]),
		.general_io_one_out(od_out[1]),
		.general_io_one_oe(oe[1]),
		.cc_rx_pin_in(pin[2]), .cc_rx_pin_out(od_out[2]),
		.cc_rx_pin_oe(oe[2]),
		.cc_tx_pin_in(pin[3]), .cc_tx_pin_out(od_out[3]),
		.cc_tx_pin_oe(oe[3]),
		.gpio_drive_low(gpio_drive_low), .gpio_state(gpio_state),
		.cc_rx_drive_low(rx_dl), .cc_tx_drive_low(tx_dl),
		.cc_rx_level(rx_lvl), .cc_tx_level(tx_lvl),
		.cc_i2c_mode(i2c), .rate_err_clear(clr), .rate_err(rate_err),
		.stagger_disable(stag_dis), .stag(stag), .cfg(cfg),
		.cfg_valid(cfg_valid),
		.remote_input_pin(rin), .remote_output_pin(rout)
	);

	csd_board_model i_csd_board_model (
		.strap_mode(strap_mode), .strap_level(strap_level),
		.peer_low(peer_low), .dut_oe(oe), .pin_level(pin)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// repeatable pseudo-random source
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	// latched configuration expected from the pin levels
	function automatic csd_pkg::csd_strap_t exp_cfg(input logic cc,
			input logic ms, input logic [3:0] st);
		csd_pkg::csd_strap_t r;
		r = 7'h00;
		r.local_cc_en = cc;
		if (cc) begin
			r.bypass_mode = ms;
		end else begin
			r.double_out = st[0];
			r.bus_32 = st[1];
			r.sync_enc = ms;
			r.ecc_en = st[2];
			r.fall_edge = st[3];
		end
		return r;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// reset with straps set, then wait for the latch under a bound
	task automatic power_up(input logic cc, input logic ms,
			input logic [3:0] st);
		int i;
		rst = 1'h1;
		lcc = cc;
		msel = ms;
		strap_mode = !cc;
		strap_level = st;
		peer_low = 4'h0;
		gpio_drive_low = 2'h0;
		rx_dl = 1'h0;
		tx_dl = 1'h0;
		cyc(8);
		rst = 1'h0;
		i = 0;
		while (cfg_valid !== 1'b1 && i < 40) begin
			cyc(1);
			i++;
		end
		e = exp_cfg(cc, ms, st);
		`CHK("cfg_valid", 1'b1, cfg_valid)
		`CHK("cfg", e, cfg)
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// whole run is under a thousand cycles, so this bound is generous
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		final_report();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		lfsr = 16'h59ae;
		{rst, lcc, msel, strap_mode, rx_dl, tx_dl} = 6'h21;
		{i2c, clr, stag_dis, rin} = 4'h0;
		strap_level = 4'h0;
		peer_low = 4'h0;
		gpio_drive_low = 2'h0;
		num_errors = 0;
		n_checks = 0;
		cyc(1);
		// strap mode: corners first, then random straps
		for (k = 0; k < 5; k++) begin
			v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : rnd();
			power_up(1'h0, v[4], v[3:0]);
			// later pin changes and core drive must be ignored
			strap_level = ~v[3:0];
			msel = ~v[4];
			gpio_drive_low = 2'h3;
			rx_dl = 1'h1;
			tx_dl = 1'h1;
			cyc(4);
			`CHK("cfg held", e, cfg)
			`CHK("oe", 4'h0, oe)
			`CHK("gpio_state", 2'h3, gpio_state)
			`CHK("cc levels", 2'h3, {tx_lvl, rx_lvl})
		end
		$display("test strap decode done");
		// stagger codes follow the disable control
		for (k = 0; k < 4; k++) begin
			stag_dis = k[0];
			cyc(2);
			`CHK("stag", k[0] ? 15'h0000 : {3'h0, 3'h2, 3'h4, 3'h6, 3'h3}, stag)
		end
		$display("test stagger done");
		// control channel owns the pins
		for (k = 0; k < 2; k++) begin
			power_up(1'h1, k[0], 4'h0);
		end
		for (k = 0; k < 8; k++) begin
			v = rnd();
			{tx_dl, rx_dl, gpio_drive_low} = v[3:0];
			peer_low = v[7:4];
			cyc(3);
			`CHK("oe", v[3:0], oe)
			`CHK("od out", 4'h0, od_out)
			`CHK("gpio_state", ~(v[1:0] | v[5:4]), gpio_state)
			`CHK("cc levels", ~(v[3:2] | v[7:6]), {tx_lvl, rx_lvl})
		end
		{tx_dl, rx_dl, gpio_drive_low} = 4'h0;
		peer_low = 4'h0;
		$display("test pin ownership done");
		// rate guard: too-fast pairs flag, lawful spacing does not
		for (k = 0; k < 4; k++) begin
			i2c = k[1];
			cyc(70);
			clr = 1'h1;
			cyc(1);
			clr = 1'h0;
			cyc(1);
			`CHK("rate_err cleared", 1'b0, rate_err)
			peer_low[i2c ? 3 : 2] = 1'h1;
			// spacing one below and exactly at the least lawful gap
			cyc(k[1] ? (k[0] ? 63 : 62) : (k[0] ? 50 : 49));
			peer_low = 4'h0;
			cyc(4);
			`CHK("rate_err", !k[0], rate_err)
		end
		$display("test rate guard done");
		// remote forwarding, transitions spaced beyond the count
		for (k = 0; k < 8; k++) begin
			v = rnd();
			rin = (k < 3) ? ~rin : v[0];
			cyc(fwd_n);
			`CHK("remote out", rin, rout)
			cyc(2);
		end
		$display("test remote forward done");
		final_report();
	end
endmodule
